// [common/gpc_regs.svh]
/*
  Register offsets, field positions, reset values and scale constants of the
  per-phase gain and phase-offset calibration block.
  Assumes inclusion by bare name from any file that needs the register map.
*/
`ifndef GPC_REGS_SVH
`define GPC_REGS_SVH

// Register addresses on the documented register port (16-bit address)
`define GPC_ADDR_V_GAIN 16'h0138
`define GPC_ADDR_I_GAIN 16'h013A
`define GPC_ADDR_OFF_HIGH 16'h013E
`define GPC_ADDR_OFF_MID 16'h0140
`define GPC_ADDR_OFF_LOW 16'h0142
`define GPC_ADDR_THR_LOWER 16'h0144
`define GPC_ADDR_THR_UPPER 16'h0146
`define GPC_ADDR_STATUS 16'h0148

// Reset values
`define GPC_GAIN_UNITY 16'h4000
`define GPC_OFF_RESET 16'h0000
`define GPC_THR_RESET 16'h0000

// Gain is unsigned fixed point with 14 fraction bits; bit 15 always zero
`define GPC_GAIN_FRAC 14
`define GPC_GAIN_MSB 15

// Phase offset holds radians times 2^16, stored verbatim
`define GPC_PHASE_FRAC 16

// Threshold LSB is full scale/2^16, RMS LSB is full scale/2^24
`define GPC_THR_SHIFT 8

`endif

// [common/gpc_pkg.sv]
/*
  Types of the gain and phase-offset calibration block.
  Assumes gpc_regs.svh supplies numeric constants; nothing here is imported.
*/
package gpc_pkg;

  // Selected current range, one-hot
  typedef enum logic [2:0] {
    GPC_RANGE_LOW = 3'b001,
    GPC_RANGE_MID = 3'b010,
    GPC_RANGE_HIGH = 3'b100
  } gpc_range_t;

  // One register access on the documented register port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } gpc_reg_req_t;

  // One pair of raw RMS results for the phase
  typedef struct packed {
    logic valid;
    logic [31:0] current;
    logic [31:0] voltage;
  } gpc_rms_t;

endpackage : gpc_pkg

// [hdl/gpc_gain_mul.sv]
/*
  Fixed-point gain stage: out = in * gain / 2^FRAC, saturated, registered.
  Assumes a synchronous active-low reset and gain bit 15 held at zero.
*/
`timescale 1ns/1ps
module gpc_gain_mul #(
  parameter int W = 32,
  parameter int GW = 16,
  parameter int FRAC = 14
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Raw value in
  input wire logic in_valid,
  input wire logic [W-1:0] in_val,
  input wire logic [GW-1:0] gain,
  // Corrected value out
  output logic out_valid,
  output logic [W-1:0] out_val
);

  logic [W+GW-1:0] prod;
  logic [W+GW-1:0] shifted;
  logic ovf;
  logic [W-1:0] sat_val;
  logic out_valid_q;
  logic [W-1:0] out_val_q;

  // Gains up to two can overflow the result width, so clamp at full scale
  assign prod = in_val * gain;
  assign shifted = prod >> FRAC;
  assign ovf = |shifted[W+GW-1:W];
  assign sat_val = ovf ? {W{1'b1}} : shifted[W-1:0];

  // Result register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_valid_q <= 1'b0;
      out_val_q <= '0;
    end else begin
      out_valid_q <= in_valid;
      if (in_valid) begin
        out_val_q <= sat_val;
      end
    end
  end

  assign out_valid = out_valid_q;
  assign out_val = out_val_q;

endmodule : gpc_gain_mul

// [hdl/gpc_calib.sv]
/*
  Per-phase gain and phase-offset calibration: applies current and voltage
  gain to the raw RMS results and picks one of three phase offsets by the
  current range that the corrected current falls in.
  Assumes the host drives the register port synchronously to clk, one access
  per cycle, and reloads every calibration constant after each reset.
*/
// Functional notes
// - A gain register value of 0x4000 means unity gain and is the reset and clearing value.
// - Gain equals the ratio times 16384, lies between zero and two, and has bit 15 zero.
// - A phase offset register holds the angle in radians times 65536 as a raw integer.
// - Three phase offsets are kept and one is applied for the low, mid or high range.
// - With both range thresholds at zero the high-range offset covers the whole range.
// - The phase offset for the high range sits at register address 0x13E.
`timescale 1ns/1ps
`include "gpc_regs.svh"
module gpc_calib #(
  parameter int RMS_W = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Documented register port
  input wire gpc_pkg::gpc_reg_req_t reg_req,
  output logic reg_rvalid_q,
  output logic [15:0] reg_rdata_q,
  // Raw RMS results
  input wire gpc_pkg::gpc_rms_t rms_in,
  // Calibrated results
  output logic cal_valid_q,
  output logic [RMS_W-1:0] phase_a_current_rms_q,
  output logic [RMS_W-1:0] phase_a_voltage_rms_q,
  output logic [15:0] phase_offset_q,
  output gpc_pkg::gpc_range_t range_q
);

  // Calibration registers
  logic [15:0] v_gain_q;
  logic [15:0] i_gain_q;
  logic [15:0] off_high_q;
  logic [15:0] off_mid_q;
  logic [15:0] off_low_q;
  logic [15:0] thr_lower_q;
  logic [15:0] thr_upper_q;

  // Address decode
  logic wr_v_gain;
  logic wr_i_gain;
  logic wr_off_high;
  logic wr_off_mid;
  logic wr_off_low;
  logic wr_thr_lower;
  logic wr_thr_upper;
  logic [15:0] gain_wdata;
  logic [15:0] rd_mux;

  assign wr_v_gain = reg_req.wr && (reg_req.addr == `GPC_ADDR_V_GAIN);
  assign wr_i_gain = reg_req.wr && (reg_req.addr == `GPC_ADDR_I_GAIN);
  assign wr_off_high = reg_req.wr && (reg_req.addr == `GPC_ADDR_OFF_HIGH);
  assign wr_off_mid = reg_req.wr && (reg_req.addr == `GPC_ADDR_OFF_MID);
  assign wr_off_low = reg_req.wr && (reg_req.addr == `GPC_ADDR_OFF_LOW);
  assign wr_thr_lower = reg_req.wr && (reg_req.addr == `GPC_ADDR_THR_LOWER);
  assign wr_thr_upper = reg_req.wr && (reg_req.addr == `GPC_ADDR_THR_UPPER);

  // Gain MSB forced to zero so the ratio can never reach two or more
  assign gain_wdata = {1'b0, reg_req.wdata[`GPC_GAIN_MSB-1:0]};

  // Gain registers, unity after reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      v_gain_q <= `GPC_GAIN_UNITY;
      i_gain_q <= `GPC_GAIN_UNITY;
    end else begin
      if (wr_v_gain) v_gain_q <= gain_wdata;
      if (wr_i_gain) i_gain_q <= gain_wdata;
    end
  end

  // Phase offsets stored verbatim as angle times 2^16
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      off_high_q <= `GPC_OFF_RESET;
      off_mid_q <= `GPC_OFF_RESET;
      off_low_q <= `GPC_OFF_RESET;
    end else begin
      if (wr_off_high) off_high_q <= reg_req.wdata;
      if (wr_off_mid) off_mid_q <= reg_req.wdata;
      if (wr_off_low) off_low_q <= reg_req.wdata;
    end
  end

  // Range thresholds, zero by default
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      thr_lower_q <= `GPC_THR_RESET;
      thr_upper_q <= `GPC_THR_RESET;
    end else begin
      if (wr_thr_lower) thr_lower_q <= reg_req.wdata;
      if (wr_thr_upper) thr_upper_q <= reg_req.wdata;
    end
  end

  // Read mux; unmapped addresses read zero
  assign rd_mux =
    (reg_req.addr == `GPC_ADDR_V_GAIN) ? v_gain_q :
    (reg_req.addr == `GPC_ADDR_I_GAIN) ? i_gain_q :
    (reg_req.addr == `GPC_ADDR_OFF_HIGH) ? off_high_q :
    (reg_req.addr == `GPC_ADDR_OFF_MID) ? off_mid_q :
    (reg_req.addr == `GPC_ADDR_OFF_LOW) ? off_low_q :
    (reg_req.addr == `GPC_ADDR_THR_LOWER) ? thr_lower_q :
    (reg_req.addr == `GPC_ADDR_THR_UPPER) ? thr_upper_q :
    (reg_req.addr == `GPC_ADDR_STATUS) ? {13'h0000, range_q} :
    16'h0000;

  // Read answer one cycle after the request
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rvalid_q <= 1'b0;
      reg_rdata_q <= 16'h0000;
    end else begin
      reg_rvalid_q <= reg_req.rd;
      if (reg_req.rd) reg_rdata_q <= rd_mux;
    end
  end

  // Gain stages
  logic i_mul_valid;
  logic [RMS_W-1:0] i_mul_val;
  logic v_mul_valid;
  logic [RMS_W-1:0] v_mul_val;

  gpc_gain_mul #(.W(RMS_W), .GW(16), .FRAC(`GPC_GAIN_FRAC)) u_i_gain (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(rms_in.valid),
    .in_val(rms_in.current[RMS_W-1:0]),
    .gain(i_gain_q),
    .out_valid(i_mul_valid),
    .out_val(i_mul_val)
  );

  gpc_gain_mul #(.W(RMS_W), .GW(16), .FRAC(`GPC_GAIN_FRAC)) u_v_gain (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(rms_in.valid),
    .in_val(rms_in.voltage[RMS_W-1:0]),
    .gain(v_gain_q),
    .out_valid(v_mul_valid),
    .out_val(v_mul_val)
  );

  // Range decision on the corrected current, scaled to threshold units
  logic [RMS_W-`GPC_THR_SHIFT-1:0] cur_mag;
  logic thr_both_zero;
  logic below_lower;
  logic below_upper;
  gpc_pkg::gpc_range_t range_d;
  logic [15:0] offset_d;

  assign cur_mag = i_mul_val[RMS_W-1:`GPC_THR_SHIFT];
  assign thr_both_zero = (thr_lower_q == 16'h0000) && (thr_upper_q == 16'h0000);
  assign below_lower = cur_mag < (RMS_W-`GPC_THR_SHIFT)'(thr_lower_q);
  assign below_upper = cur_mag < (RMS_W-`GPC_THR_SHIFT)'(thr_upper_q);
  assign range_d =
    thr_both_zero ? gpc_pkg::GPC_RANGE_HIGH :
    below_lower ? gpc_pkg::GPC_RANGE_LOW :
    below_upper ? gpc_pkg::GPC_RANGE_MID :
    gpc_pkg::GPC_RANGE_HIGH;
  assign offset_d =
    (range_d == gpc_pkg::GPC_RANGE_LOW) ? off_low_q :
    (range_d == gpc_pkg::GPC_RANGE_MID) ? off_mid_q :
    off_high_q;

  // Output stage: offset and corrected results move together
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cal_valid_q <= 1'b0;
      phase_a_current_rms_q <= '0;
      phase_a_voltage_rms_q <= '0;
      phase_offset_q <= 16'h0000;
      range_q <= gpc_pkg::GPC_RANGE_HIGH;
    end else begin
      cal_valid_q <= i_mul_valid && v_mul_valid;
      if (i_mul_valid) begin
        phase_a_current_rms_q <= i_mul_val;
        phase_a_voltage_rms_q <= v_mul_val;
        phase_offset_q <= offset_d;
        range_q <= range_d;
      end
    end
  end

  // Checks
  property p_unity_reset;
    @(posedge clk) !rst_n |=> (i_gain_q == `GPC_GAIN_UNITY) && (v_gain_q == `GPC_GAIN_UNITY);
  endproperty
  a_unity_reset: assert property (p_unity_reset) else $error("gain not unity after reset");

  property p_unity_pass;
    @(posedge clk) disable iff (!rst_n)
      rms_in.valid && (i_gain_q == `GPC_GAIN_UNITY) |=> (i_mul_val == $past(rms_in.current));
  endproperty
  a_unity_pass: assert property (p_unity_pass) else $error("unity gain altered current");

  property p_gain_msb;
    @(posedge clk) disable iff (!rst_n)
      wr_i_gain |=> !i_gain_q[15] && (i_gain_q[14:0] == $past(reg_req.wdata[14:0]));
  endproperty
  a_gain_msb: assert property (p_gain_msb) else $error("current gain write wrong");

  property p_off_store;
    @(posedge clk) disable iff (!rst_n) wr_off_low |=> (off_low_q == $past(reg_req.wdata));
  endproperty
  a_off_store: assert property (p_off_store) else $error("offset not stored verbatim");

  property p_high_addr;
    @(posedge clk) disable iff (!rst_n)
      reg_req.wr && (reg_req.addr == 16'h013E) ##1 reg_req.rd && (reg_req.addr == 16'h013E)
      |=> reg_rvalid_q && (reg_rdata_q == $past(reg_req.wdata, 2));
  endproperty
  a_high_addr: assert property (p_high_addr) else $error("high offset not at 0x13E");

  property p_zero_thr;
    @(posedge clk) disable iff (!rst_n)
      i_mul_valid && thr_both_zero |=> (range_q == gpc_pkg::GPC_RANGE_HIGH)
        && (phase_offset_q == $past(off_high_q));
  endproperty
  a_zero_thr: assert property (p_zero_thr) else $error("zero thresholds not high range");

  property p_low_sel;
    @(posedge clk) disable iff (!rst_n)
      i_mul_valid && !thr_both_zero && below_lower |=> (range_q == gpc_pkg::GPC_RANGE_LOW)
        && (phase_offset_q == $past(off_low_q));
  endproperty
  a_low_sel: assert property (p_low_sel) else $error("low range not selected");

  property p_mid_sel;
    @(posedge clk) disable iff (!rst_n)
      i_mul_valid && !thr_both_zero && !below_lower && below_upper
        |=> (range_q == gpc_pkg::GPC_RANGE_MID) && (phase_offset_q == $past(off_mid_q));
  endproperty
  a_mid_sel: assert property (p_mid_sel) else $error("mid range not selected");

endmodule : gpc_calib

// [dv/gpc_host_model.sv]
/*
  Host model for the calibration block: register writes and reads with
  one-cycle strobes launched at the falling edge of clk.
  Assumes the bench owns clk and calls the tasks one at a time.
*/
`timescale 1ns/1ps
module gpc_host_model (
  // Clock
  input wire logic clk,
  // Register port toward the block
  output gpc_pkg::gpc_reg_req_t reg_req,
  input wire logic reg_rvalid_q,
  input wire logic [15:0] reg_rdata_q
);
  // Idle port carries the inverse of the last request, never stale values
  initial reg_req = '0;

  // One write strobe, then release
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk);
    reg_req <= '{1'b1, 1'b0, a, d};
    @(negedge clk);
    reg_req <= '{1'b0, 1'b0, ~a, ~d};
  endtask : wr

  // Answer stands one cycle, one edge after the taking edge
  task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic ok);
    @(negedge clk);
    reg_req <= '{1'b0, 1'b1, a, 16'h0000};
    @(negedge clk);
    ok = reg_rvalid_q;
    d = reg_rdata_q;
    reg_req <= '{1'b0, 1'b0, ~a, 16'hFFFF};
  endtask : rd

  // Write then read of one address on adjacent edges, no idle cycle between
  task automatic wr_rd(input logic [15:0] a, input logic [15:0] d, output logic [15:0] q,
    output logic ok);
    @(negedge clk);
    reg_req <= '{1'b1, 1'b0, a, d};
    @(negedge clk);
    reg_req <= '{1'b0, 1'b1, a, 16'h0000};
    @(negedge clk);
    ok = reg_rvalid_q;
    q = reg_rdata_q;
    reg_req <= '{1'b0, 1'b0, ~a, 16'hFFFF};
  endtask : wr_rd
endmodule : gpc_host_model

// [dv/gpc_calib_bench.sv]
/*
  Self-checking bench of the calibration block with a shadow register model.
  Assumes gpc_host_model drives the register port and clk runs at 125 MHz.
*/
`timescale 1ns/1ps
`include "gpc_regs.svh"
module gpc_calib_bench;
  logic clk = 1'b0;
  logic rst_n;
  gpc_pkg::gpc_reg_req_t reg_req;
  gpc_pkg::gpc_rms_t rms_in;
  logic reg_rvalid_q;
  logic [15:0] reg_rdata_q;
  logic cal_valid_q;
  logic [31:0] i_rms;
  logic [31:0] v_rms;
  logic [15:0] phase_offset_q;
  gpc_pkg::gpc_range_t range_q;
  logic [15:0] sh [logic [15:0]];
  logic [31:0] seed;
  int errors;
  int cmp_count;
  int cycles = 0;

  // 8 ns period
  always #4 clk = ~clk;

  gpc_calib i_gpc_calib (.clk(clk), .rst_n(rst_n), .reg_req(reg_req),
    .reg_rvalid_q(reg_rvalid_q), .reg_rdata_q(reg_rdata_q), .rms_in(rms_in),
    .cal_valid_q(cal_valid_q), .phase_a_current_rms_q(i_rms),
    .phase_a_voltage_rms_q(v_rms), .phase_offset_q(phase_offset_q), .range_q(range_q));
  gpc_host_model i_gpc_host_model (.clk(clk), .reg_req(reg_req),
    .reg_rvalid_q(reg_rvalid_q), .reg_rdata_q(reg_rdata_q));

  // Cuts a hang short; the run needs about 240 cycles
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      summarize();
    end
  end

  task automatic summarize();
    if (errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count = cmp_count + 1;
    if (g !== e) begin
      errors = errors + 1;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [15:0] addr(input int k);
    // Gap at 0x13C between the gains and the offsets
    return (k < 2) ? 16'h0138 + 16'(2 * k) : 16'h013A + 16'(2 * k);
  endfunction : addr

  // Shadow back to reset state: gains unity, the rest zero
  task automatic clear();
    for (int k = 0; k < 7; k++) sh[addr(k)] = (k < 2) ? 16'h4000 : 16'h0000;
  endtask : clear

  // Gains keep bit 15 clear
  task automatic w(input logic [15:0] a, input logic [15:0] d);
    i_gpc_host_model.wr(a, d);
    if (sh.exists(a)) sh[a] = (a < `GPC_ADDR_OFF_HIGH) ? (d & 16'h7FFF) : d;
  endtask : w

  task automatic r(input logic [15:0] a);
    logic [15:0] d;
    logic ok;
    i_gpc_host_model.rd(a, d, ok);
    chk("rvalid", 32'h00000001, ok);
    chk("rdata", sh.exists(a) ? sh[a] : 16'h0000, d);
  endtask : r

  // Write and read back on adjacent edges
  task automatic wr2(input logic [15:0] a, input logic [15:0] d);
    logic [15:0] q;
    logic ok;
    i_gpc_host_model.wr_rd(a, d, q, ok);
    if (sh.exists(a)) sh[a] = (a < `GPC_ADDR_OFF_HIGH) ? (d & 16'h7FFF) : d;
    chk("rvalid", 32'h00000001, ok);
    chk("rdata", sh.exists(a) ? sh[a] : 16'h0000, q);
  endtask : wr2

  // Gains first, offsets cleared before use, short settle instead of seconds
  task automatic load(input logic [15:0] vals [7]);
    for (int k = 0; k < 2; k++) w(addr(k), vals[k]);
    repeat (4) @(negedge clk);
    for (int k = 2; k < 5; k++) w(addr(k), 16'h0000);
    for (int k = 2; k < 7; k++) w(addr(k), vals[k]);
  endtask : load

  // One RMS pair in, expectation from the shadow, result two edges on
  task automatic rms(input logic [31:0] c, input logic [31:0] v);
    logic [63:0] pi;
    logic [63:0] pv;
    logic [31:0] ei;
    logic [23:0] mag;
    logic [2:0] rg;
    pi = ({32'h00000000, c} * {48'h000000000000, sh[`GPC_ADDR_I_GAIN]}) >> 14;
    pv = ({32'h00000000, v} * {48'h000000000000, sh[`GPC_ADDR_V_GAIN]}) >> 14;
    ei = (|pi[63:32]) ? 32'hFFFFFFFF : pi[31:0];
    mag = ei[31:8];
    if (sh[`GPC_ADDR_THR_LOWER] == 0 && sh[`GPC_ADDR_THR_UPPER] == 0) rg = 3'h4;
    else if (mag < sh[`GPC_ADDR_THR_LOWER]) rg = 3'h1;
    else if (mag < sh[`GPC_ADDR_THR_UPPER]) rg = 3'h2;
    else rg = 3'h4;
    @(negedge clk);
    rms_in <= '{1'b1, c, v};
    @(negedge clk);
    rms_in <= '{1'b0, ~c, ~v};
    @(negedge clk);
    chk("cal_valid", 32'h00000001, cal_valid_q);
    chk("current", ei, i_rms);
    chk("voltage", (|pv[63:32]) ? 32'hFFFFFFFF : pv[31:0], v_rms);
    chk("range", rg, range_q);
    chk("offset", sh[addr(rg == 3'h1 ? 4 : rg == 3'h2 ? 3 : 2)], phase_offset_q);
  endtask : rms

  // Main sequence
  initial begin
    logic [31:0] bnd [4];
    bnd = '{32'h0000FFFF, 32'h00010000, 32'h0007FFFF, 32'h00080000};
    rst_n = 1'b0;
    rms_in = '0;
    errors = 0;
    cmp_count = 0;
    seed = 32'h000136CB;
    clear();
    repeat (8) @(negedge clk);
    rst_n <= 1'b1;
    for (int k = 0; k < 7; k++) r(addr(k));
    r(16'h014A);
    w(`GPC_ADDR_I_GAIN, 16'hFFFF);
    r(`GPC_ADDR_I_GAIN);
    w(`GPC_ADDR_OFF_HIGH, 16'h0260);
    r(`GPC_ADDR_OFF_HIGH);
    wr2(`GPC_ADDR_OFF_HIGH, 16'h0260);
    rms(32'hFFFFFFFF, 32'h00708029);
    for (int k = 0; k < 16; k++) begin
      seed = lfsr(seed);
      rms(seed, ~seed);
    end
    load('{16'h3EA1, 16'h4000, 16'h0260, 16'h0111, 16'h0222, 16'h0100, 16'h0800});
    for (int k = 0; k < 4; k++) rms(bnd[k], 32'h00708029);
    // Last boundary value lands in the high range, seen through the status word
    sh[`GPC_ADDR_STATUS] = 16'h0004;
    r(`GPC_ADDR_STATUS);
    for (int k = 0; k < 16; k++) begin
      seed = lfsr(seed);
      rms(seed & 32'h000FFFFF, seed);
    end
    @(negedge clk);
    rst_n <= 1'b0;
    repeat (8) @(negedge clk);
    rst_n <= 1'b1;
    clear();
    r(`GPC_ADDR_I_GAIN);
    rms(32'h00012345, 32'h00054321);
    load('{16'h4100, 16'h3F00, 16'h0033, 16'h0044, 16'h0055, 16'h0020, 16'h0040});
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      rms(seed & 32'h00007FFF, seed);
    end
    summarize();
  end
endmodule : gpc_calib_bench
